// ===== dv/pad_alternate_function_mux_tb.sv
// Self-checking bench for the pad function multiplexer
`timescale 1ns/1ns
`default_nettype none
module pad_alternate_function_mux_tb
  import pad_mux_pkg::*;
;
  localparam logic [3:0] OUT_PAT = 4'hA;
  localparam logic [3:0] OE_PAT = 4'h3;
  logic sys_clk;
  logic reset_n;
  logic clk_en;
  logic cfg_we;
  logic [PAD_IDX_W-1:0] cfg_pad;
  logic [CFG_W-1:0] cfg_wdata;
  logic [CFG_W-1:0] cfg_rdata;
  logic src_we;
  logic [SRC_IDX_W-1:0] src_idx;
  logic [SRC_SEL_W-1:0] src_wdata;
  logic [SRC_SEL_W-1:0] src_rdata;
  logic [PAD_COUNT-1:0][ALT_COUNT-1:0] alt_out;
  logic [PAD_COUNT-1:0][ALT_COUNT-1:0] alt_oe;
  logic [PAD_COUNT-1:0] pad_in;
  logic [PAD_COUNT-1:0] pad_out;
  logic [PAD_COUNT-1:0] pad_oe;
  logic [PAD_COUNT-1:0] pad_ibe;
  logic [PAD_COUNT-1:0][1:0] pad_speed;
  logic [PAD_COUNT-1:0] pad_pulldown;
  logic [PAD_COUNT-1:0] periph_rx;
  logic [SRC_COUNT-1:0] src_rx;
  logic external_irq_line_9;
  int n_fail;
  int num_checks;

  pad_alternate_function_mux dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .cfg_we(cfg_we), .cfg_pad(cfg_pad), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .src_we(src_we), .src_idx(src_idx), .src_wdata(src_wdata), .src_rdata(src_rdata),
    .alt_out(alt_out), .alt_oe(alt_oe), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_ibe(pad_ibe), .pad_speed(pad_speed),
    .pad_pulldown(pad_pulldown), .periph_rx(periph_rx), .src_rx(src_rx),
    .external_irq_line_9(external_irq_line_9)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Lets the registered outputs land before sampling
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic cfg_write(input logic [3:0] p, input logic [3:0] d);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_pad <= p;
    cfg_wdata <= d;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask : cfg_write

  task automatic src_write(input logic [1:0] k, input logic [3:0] d);
    @(posedge sys_clk);
    src_we <= 1'b1;
    src_idx <= k;
    src_wdata <= d;
    @(posedge sys_clk);
    src_we <= 1'b0;
  endtask : src_write

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    cfg_we = 1'b0;
    cfg_pad = 4'h0;
    cfg_wdata = 4'h0;
    src_we = 1'b0;
    src_idx = 2'h0;
    src_wdata = 4'h0;
    alt_out = '0;
    alt_oe = '0;
    pad_in = 16'h0000;
    settle(2);
    check(pad_pulldown, PULLDOWN_MASK);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    settle(1);
    check(pad_pulldown, 16'h0000);
    for (int p = 0; p < PAD_COUNT; p++) begin
      @(posedge sys_clk);
      cfg_pad <= p[3:0];
      settle(2);
      check(cfg_rdata, CFG_RESET);
    end
    $display("test reset done");
    @(posedge sys_clk);
    alt_out[10] <= OUT_PAT;
    alt_oe[10] <= OE_PAT;
    for (int s = 0; s < ALT_COUNT; s++) begin
      cfg_write(4'hA, {2'h0, s[1:0]});
      settle(3);
      check(pad_out[10], OUT_PAT[s]);
      check(pad_oe[10], OE_PAT[s]);
      check(cfg_rdata, {2'h0, s[1:0]});
    end
    $display("test select done");
    cfg_write(4'hA, 4'h8);
    settle(3);
    check(pad_speed[10], SPEED_MEDIUM);
    cfg_write(4'hA, 4'h0);
    settle(3);
    check(pad_speed[10], SPEED_SLOW);
    // Writes while frozen must be ignored
    @(posedge sys_clk);
    clk_en <= 1'b0;
    cfg_write(4'hA, 4'h8);
    clk_en <= 1'b1;
    settle(3);
    check(pad_speed[10], SPEED_SLOW);
    $display("test slew done");
    @(posedge sys_clk);
    pad_in <= 16'h0408;
    cfg_write(4'hA, 4'h3);
    settle(8);
    check(pad_ibe[10], 1'b0);
    check(periph_rx[10], 1'b0);
    check(external_irq_line_9, 1'b0);
    cfg_write(4'hA, 4'h4);
    cfg_write(4'h3, 4'h4);
    settle(8);
    check(pad_ibe[10], 1'b1);
    check(periph_rx[10], 1'b1);
    check(periph_rx[3], 1'b1);
    check(external_irq_line_9, 1'b1);
    // Input delivery must not depend on the select field
    cfg_write(4'hA, 4'h7);
    settle(3);
    check(pad_out[10], OUT_PAT[3]);
    check(pad_ibe[10], 1'b1);
    check(periph_rx[10], 1'b1);
    check(external_irq_line_9, 1'b1);
    $display("test input done");
    @(posedge sys_clk);
    pad_in <= 16'h0008;
    for (int k = 0; k < SRC_COUNT; k++) begin
      src_write(k[1:0], k[0] ? 4'h3 : 4'hA);
    end
    settle(8);
    for (int k = 0; k < SRC_COUNT; k++) begin
      check(src_rx[k], k[0]);
      @(posedge sys_clk);
      src_idx <= k[1:0];
      settle(2);
      check(src_rdata, k[0] ? 4'h3 : 4'hA);
    end
    @(posedge sys_clk);
    pad_in <= 16'h0400;
    settle(8);
    for (int k = 0; k < SRC_COUNT; k++) begin
      check(src_rx[k], !k[0]);
    end
    $display("test source done");
    @(posedge sys_clk);
    cfg_pad <= 4'hA;
    reset_n <= 1'b0;
    settle(2);
    check(pad_pulldown, PULLDOWN_MASK);
    check(cfg_rdata, CFG_RESET);
    check(pad_oe, 16'h0000);
    @(posedge sys_clk);
    reset_n <= 1'b1;
    settle(3);
    check(cfg_rdata, CFG_RESET);
    $display("test rereset done");
    wrap_up();
  end
endmodule : pad_alternate_function_mux_tb
`default_nettype wire

// ===== verilog/pad_alternate_function_mux.sv
// Per-pad alternate function multiplexer with input routing
`timescale 1ns/1ns
`default_nettype none
module pad_alternate_function_mux
  import pad_mux_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pad configuration write and readback
  input wire logic cfg_we,
  input wire logic [PAD_IDX_W-1:0] cfg_pad,
  input wire logic [CFG_W-1:0] cfg_wdata,
  output logic [CFG_W-1:0] cfg_rdata,
  // Peripheral input source select
  input wire logic src_we,
  input wire logic [SRC_IDX_W-1:0] src_idx,
  input wire logic [SRC_SEL_W-1:0] src_wdata,
  output logic [SRC_SEL_W-1:0] src_rdata,
  // Peripheral outputs, four alternates per pad
  input wire logic [PAD_COUNT-1:0][ALT_COUNT-1:0] alt_out,
  input wire logic [PAD_COUNT-1:0][ALT_COUNT-1:0] alt_oe,
  // Pads
  input wire logic [PAD_COUNT-1:0] pad_in,
  output logic [PAD_COUNT-1:0] pad_out,
  output logic [PAD_COUNT-1:0] pad_oe,
  output logic [PAD_COUNT-1:0] pad_ibe,
  output logic [PAD_COUNT-1:0][1:0] pad_speed,
  output logic [PAD_COUNT-1:0] pad_pulldown,
  // Peripheral inputs
  output logic [PAD_COUNT-1:0] periph_rx,
  output logic [SRC_COUNT-1:0] src_rx,
  output logic external_irq_line_9
);
  logic [CFG_W-1:0] pad_config_reg_q [PAD_COUNT];
  logic [CFG_W-1:0] pad_config_reg_d [PAD_COUNT];
  logic [SRC_SEL_W-1:0] input_source_select_q [SRC_COUNT];
  logic [SRC_SEL_W-1:0] input_source_select_d [SRC_COUNT];
  logic [PAD_COUNT-1:0] out_q, out_d, oe_q, oe_d, ibe_q, ibe_d, pd_q, pd_d;
  logic [PAD_COUNT-1:0] rx_q, rx_d;
  logic [PAD_COUNT-1:0][1:0] speed_q, speed_d;
  logic [SRC_COUNT-1:0] src_rx_q, src_rx_d;
  logic irq_q, irq_d;
  logic [CFG_W-1:0] cfg_rd_q, cfg_rd_d;
  logic [SRC_SEL_W-1:0] src_rd_q, src_rd_d;

  pad_rx_if rx_if ();

  pad_input_sync u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pad_in(pad_in),
    .rx(rx_if.producer)
  );

  function automatic logic [1:0] alt_sel(input logic [CFG_W-1:0] cfg);
    return cfg[CFG_ALT_LSB +: CFG_ALT_W];
  endfunction : alt_sel

  function automatic logic [1:0] speed_of(input logic [CFG_W-1:0] cfg, input logic fast_pad);
    if (!cfg[CFG_SLEW_BIT]) begin
      return SPEED_SLOW;
    end else if (fast_pad) begin
      return SPEED_FAST;
    end else begin
      return SPEED_MEDIUM;
    end
  endfunction : speed_of

  // Configuration storage
  always_comb begin
    pad_config_reg_d = pad_config_reg_q;
    input_source_select_d = input_source_select_q;
    if (clk_en && cfg_we) begin
      pad_config_reg_d[cfg_pad] = cfg_wdata;
    end
    if (clk_en && src_we) begin
      input_source_select_d[src_idx] = src_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < PAD_COUNT; i++) begin
        pad_config_reg_q[i] <= CFG_RESET;
      end
      for (int k = 0; k < SRC_COUNT; k++) begin
        input_source_select_q[k] <= SRC_SEL_RESET;
      end
    end else begin
      pad_config_reg_q <= pad_config_reg_d;
      input_source_select_q <= input_source_select_d;
    end
  end

  // Pad drive and peripheral distribution
  always_comb begin
    out_d = out_q;
    oe_d = oe_q;
    ibe_d = ibe_q;
    speed_d = speed_q;
    rx_d = rx_q;
    src_rx_d = src_rx_q;
    irq_d = irq_q;
    cfg_rd_d = cfg_rd_q;
    src_rd_d = src_rd_q;
    pd_d = '0;
    if (clk_en) begin
      for (int i = 0; i < PAD_COUNT; i++) begin
        // select field picks alternate; pin 10 wired likewise
        out_d[i] = alt_out[i][alt_sel(pad_config_reg_q[i])];
        oe_d[i] = alt_oe[i][alt_sel(pad_config_reg_q[i])];
        // input delivery gated by buffer enable alone
        ibe_d[i] = pad_config_reg_q[i][CFG_IBE_BIT];
        // every peripheral sees the same level
        rx_d[i] = rx_if.level[i] & pad_config_reg_q[i][CFG_IBE_BIT];
        speed_d[i] = speed_of(pad_config_reg_q[i], FAST_PAD_MASK[i]);
      end
      for (int k = 0; k < SRC_COUNT; k++) begin
        src_rx_d[k] = rx_d[input_source_select_q[k]];
      end
      // pin 10 feeds irq line 9
      irq_d = rx_d[PAD_A10];
      cfg_rd_d = pad_config_reg_q[cfg_pad];
      src_rd_d = input_source_select_q[src_idx];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      out_q <= '0;
      oe_q <= '0;
      ibe_q <= '0;
      speed_q <= '0;
      rx_q <= '0;
      src_rx_q <= '0;
      irq_q <= 1'b0;
      cfg_rd_q <= CFG_RESET;
      src_rd_q <= SRC_SEL_RESET;
      pd_q <= PULLDOWN_MASK;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      ibe_q <= ibe_d;
      speed_q <= speed_d;
      rx_q <= rx_d;
      src_rx_q <= src_rx_d;
      irq_q <= irq_d;
      cfg_rd_q <= cfg_rd_d;
      src_rd_q <= src_rd_d;
      pd_q <= pd_d;
    end
  end

  assign pad_out = out_q;
  assign pad_oe = oe_q;
  assign pad_ibe = ibe_q;
  assign pad_speed = speed_q;
  assign pad_pulldown = pd_q;
  assign periph_rx = rx_q;
  assign src_rx = src_rx_q;
  assign external_irq_line_9 = irq_q;
  assign cfg_rdata = cfg_rd_q;
  assign src_rdata = src_rd_q;

  sequence cfg_write_s;
    clk_en && cfg_we && cfg_pad == PAD_A10[PAD_IDX_W-1:0];
  endsequence

  AST_ALT_ROUTE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> pad_out[PAD_A10] ==
      $past(alt_out[PAD_A10][alt_sel(pad_config_reg_q[PAD_A10])]))
    else $error("pad 10 output not from selected alternate");
  AST_WRITE_THEN_DRIVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cfg_write_s ##1 clk_en |=> pad_oe[PAD_A10] ==
      |($past(alt_oe[PAD_A10]) & (4'h1 << $past(cfg_wdata[CFG_ALT_LSB +: CFG_ALT_W], 2))))
    else $error("pad 10 enable does not follow written select");
  AST_IBE_GATES: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !pad_ibe[PAD_A10] |-> !periph_rx[PAD_A10])
    else $error("input delivered without buffer enable");
  AST_RX_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> periph_rx == ($past(rx_if.level) & $past(ibe_d)))
    else $error("pad level not distributed to peripherals");
  AST_SRC_PICK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> src_rx[0] == $past(rx_d[input_source_select_q[0]]))
    else $error("source select routed wrong pad");
  AST_SLEW_SLOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && !pad_config_reg_q[0][CFG_SLEW_BIT] |=> pad_speed[0] == SPEED_SLOW)
    else $error("slew bit low did not give slow pad");
  AST_PULLDOWN: assert property (@(posedge sys_clk)
    !reset_n |=> pad_pulldown == PULLDOWN_MASK)
    else $error("reset pull-down missing");
  AST_RESET_GPIO: assert property (@(posedge sys_clk)
    !reset_n ##1 reset_n |-> alt_sel(pad_config_reg_q[PAD_A10]) == ALT_FUNC_0)
    else $error("select field not zero after reset");
  AST_IRQ_A10: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en |=> external_irq_line_9 == $past(rx_d[PAD_A10]))
    else $error("irq line 9 not fed from pad 10");
  AST_SEL_NO_INPUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && pad_config_reg_q[PAD_A10][CFG_IBE_BIT] |=>
      periph_rx[PAD_A10] == $past(rx_if.level[PAD_A10]))
    else $error("select field affected input delivery");
endmodule : pad_alternate_function_mux
`default_nettype wire

// ===== verilog/pad_input_sync.sv
// Three-stage pad input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pad_input_sync
  import pad_mux_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Raw pads
  input wire logic [PAD_COUNT-1:0] pad_in,
  // Filtered levels
  pad_rx_if.producer rx
);
  logic [PAD_COUNT-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, lvl_q, lvl_d;

  always_comb begin
    s1_d = s1_q;
    s2_d = s2_q;
    s3_d = s3_q;
    lvl_d = lvl_q;
    if (clk_en) begin
      s1_d = pad_in;
      s2_d = s1_q;
      s3_d = s2_q;
      // Accept only once two settled stages agree
      for (int i = 0; i < PAD_COUNT; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_d[i] = s3_q[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign rx.level = lvl_q;

  AST_SYNC_AGREE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clk_en && s2_q == s3_q |=> lvl_q == $past(s3_q))
    else $error("filtered level ignored agreeing stages");
endmodule : pad_input_sync
`default_nettype wire

// ===== verilog/pad_mux_pkg.sv
// Constants shared by the pad function multiplexer
package pad_mux_pkg;
  localparam int PAD_COUNT = 16;
  localparam int PAD_IDX_W = 4;
  localparam int ALT_COUNT = 4;
  localparam int SRC_COUNT = 4;
  localparam int SRC_IDX_W = 2;
  localparam int CFG_W = 4;
  localparam int SRC_SEL_W = 4;
  // Pad configuration word layout
  localparam int CFG_ALT_LSB = 0;
  localparam int CFG_ALT_W = 2;
  localparam int CFG_IBE_BIT = 2;
  localparam int CFG_SLEW_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;
  localparam logic [SRC_SEL_W-1:0] SRC_SEL_RESET = 4'h0;
  // Alternate function codes
  localparam logic [1:0] ALT_FUNC_0 = 2'h0;
  localparam logic [1:0] ALT_FUNC_1 = 2'h1;
  localparam logic [1:0] ALT_FUNC_2 = 2'h2;
  localparam logic [1:0] ALT_FUNC_3 = 2'h3;
  // Pad speed encoding
  localparam logic [1:0] SPEED_SLOW = 2'h0;
  localparam logic [1:0] SPEED_MEDIUM = 2'h1;
  localparam logic [1:0] SPEED_FAST = 2'h2;
  // Pads whose faster setting is fast rather than medium
  localparam logic [PAD_COUNT-1:0] FAST_PAD_MASK = 16'h0000;
  // Pads that hold a weak pull-down during reset
  localparam logic [PAD_COUNT-1:0] PULLDOWN_MASK = 16'h0100;
  // Port A pin 10 and the interrupt line it feeds
  localparam int PAD_A10 = 10;
  localparam int IRQ_LINE_OF_A10 = 9;
endpackage : pad_mux_pkg

// ===== verilog/pad_rx_if.sv
// Synchronised pad levels passed between the mux modules
`timescale 1ns/1ns
`default_nettype none
interface pad_rx_if;
  import pad_mux_pkg::*;
  logic [PAD_COUNT-1:0] level;
  modport producer (output level);
  modport consumer (input level);
endinterface : pad_rx_if
`default_nettype wire
